// ===== can_acceptance_filter_control.sv
// Acceptance filter control for filters 24 to 27 with Avalon-MM register slave
// Notes on behaviour
// - One enable bit per filter; filter 27 enable at bit 31.
// - Two-bit mask choice picks acceptance mask 0 to 3.
// - Five-bit FIFO choice routes matched messages to buffer 0 to 31.
// - Filter fields change only while that filter's enable bit is zero.
// - Filter 26 uses bits 23, 22-21, 20-16; lower filters repeat pattern.
// - Whole control register read/write, zero after reset, filters disabled.
// - Read-only active flag shows controller still busy after disable.
`timescale 1ns/100ps
module can_acceptance_filter_control
    import can_filter_ctrl_pkg::*;
#(
    parameter int SHUTDOWN_COUNT = SHUTDOWN_CYCLES
)(
    input  wire logic                            i_clk_sys,
    input  wire logic                            i_rst_n,
    input  wire logic [3:0]                      i_address,
    input  wire logic                            i_read,
    input  wire logic                            i_write,
    input  wire logic [31:0]                     i_writedata,
    input  wire logic [3:0]                      i_byteenable,
    input  wire logic [ID_WIDTH-1:0]             i_rx_id,
    input  wire logic                            i_rx_valid,
    input  wire logic [FILTER_COUNT*ID_WIDTH-1:0] i_filter_ids,
    output logic [31:0]                          o_readdata,
    output logic                                 o_waitrequest,
    output logic [FILTER_COUNT-1:0]              o_filter_n_on,
    output logic [FILTER_COUNT*MASK_WIDTH-1:0]   o_filter_mask_choice,
    output logic [FILTER_COUNT*FIFO_WIDTH-1:0]   o_filter_fifo_choice,
    output logic [FILTER_COUNT-1:0]              o_filter_hit,
    output logic                                 o_controller_active_flag
);
    logic [31:0]                 acceptance_filter_control_6;
    logic [31:0]                 next_ctrl;
    logic [ID_WIDTH-1:0]         mask_reg [MASK_COUNT];
    logic [ID_WIDTH-1:0]         next_mask [MASK_COUNT];
    logic [MASK_COUNT*ID_WIDTH-1:0] mask_flat;
    logic                        module_on;
    logic                        next_module_on;
    logic [7:0]                  drain_count;
    logic [7:0]                  next_drain_count;
    logic                        next_active;
    bus_state_type               bus_state;
    bus_state_type               next_bus_state;
    logic [31:0]                 next_readdata;
    logic                        next_waitrequest;
    logic                        wr_take;
    logic                        rx_id_valid_s1;
    logic                        rx_valid_sync;
    logic [ID_WIDTH-1:0]         rx_id_s1;
    logic [ID_WIDTH-1:0]         rx_id_sync;

    function automatic logic [31:0] apply_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Slave answers one cycle after the request; waitrequest low in that cycle
    // Read data is held after the answer, so a late sample still sees the word
    always_comb begin
        next_bus_state   = BUS_IDLE;
        next_waitrequest = 1'b1;
        next_readdata    = o_readdata;
        wr_take          = 1'b0;
        case (bus_state)
            BUS_IDLE: begin
                if (i_read || i_write) begin
                    next_bus_state   = BUS_ACK;
                    next_waitrequest = 1'b0;
                    if (i_read) begin
                        if (i_address == ADDR_FILTER_CTRL) begin
                            next_readdata = acceptance_filter_control_6;
                        end else if (i_address == ADDR_MODULE_CTRL) begin
                            next_readdata = UNMAPPED_READ;
                            next_readdata[MODULE_ON_POS]   = module_on;
                            next_readdata[ACTIVE_FLAG_POS] = o_controller_active_flag;
                        end else if (i_address >= ADDR_MASK_BASE &&
                                     i_address < ADDR_MASK_BASE + 4'(MASK_COUNT)) begin
                            // Upper words read as zero instead of aliasing the masks
                            next_readdata = UNMAPPED_READ;
                            next_readdata[ID_WIDTH-1:0] = mask_reg[i_address[1:0]];
                        end else begin
                            next_readdata = UNMAPPED_READ;
                        end
                    end
                end
            end
            BUS_ACK: begin
                next_bus_state   = BUS_IDLE;
                next_waitrequest = 1'b1;
                wr_take          = i_write;
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_comb begin
        logic [31:0] merged;
        logic [31:0] mask_merged;
        merged    = apply_be(acceptance_filter_control_6, i_writedata, i_byteenable);
        mask_merged = '0;
        next_ctrl = acceptance_filter_control_6;
        if (wr_take && i_address == ADDR_FILTER_CTRL) begin
            for (int f = 0; f < FILTER_COUNT; f++) begin
                // A live filter keeps its slot, including its own enable bit
                // Reset is the only way to clear an enabled filter's enable bit
                if (!acceptance_filter_control_6[f*SLOT_WIDTH + ON_POS]) begin
                    next_ctrl[f*SLOT_WIDTH +: SLOT_WIDTH] =
                        merged[f*SLOT_WIDTH +: SLOT_WIDTH];
                end
            end
        end
        next_module_on = module_on;
        if (wr_take && i_address == ADDR_MODULE_CTRL && i_byteenable[1]) begin
            next_module_on = i_writedata[MODULE_ON_POS];
        end
        for (int m = 0; m < MASK_COUNT; m++) begin
            next_mask[m] = mask_reg[m];
            if (wr_take && i_address == (ADDR_MASK_BASE + 4'(m))) begin
                mask_merged  = apply_be({3'h0, mask_reg[m]}, i_writedata, i_byteenable);
                next_mask[m] = mask_merged[ID_WIDTH-1:0];
            end
        end
        // Busy lingers a fixed drain time after switch-off
        if (module_on) begin
            next_drain_count = 8'(SHUTDOWN_COUNT);
        end else if (drain_count != 8'h00) begin
            next_drain_count = drain_count - 8'h01;
        end else begin
            next_drain_count = drain_count;
        end
        next_active = module_on || (drain_count != 8'h00);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_state                   <= BUS_IDLE;
            o_waitrequest               <= 1'b1;
            o_readdata                  <= UNMAPPED_READ;
            acceptance_filter_control_6 <= FILTER_CTRL_RESET;
            module_on                   <= 1'b0;
            drain_count                 <= 8'h00;
            o_controller_active_flag    <= 1'b0;
            for (int m = 0; m < MASK_COUNT; m++) begin
                mask_reg[m] <= '0;
            end
        end else begin
            bus_state                   <= next_bus_state;
            o_waitrequest               <= next_waitrequest;
            o_readdata                  <= next_readdata;
            acceptance_filter_control_6 <= next_ctrl;
            module_on                   <= next_module_on;
            drain_count                 <= next_drain_count;
            o_controller_active_flag    <= next_active;
            for (int m = 0; m < MASK_COUNT; m++) begin
                mask_reg[m] <= next_mask[m];
            end
        end
    end

    // Receive strobe arrives from the CAN core clock; resync before use
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_id_valid_s1 <= 1'b0;
            rx_valid_sync  <= 1'b0;
            rx_id_s1       <= '0;
            rx_id_sync     <= '0;
        end else begin
            rx_id_valid_s1 <= i_rx_valid;
            rx_valid_sync  <= rx_id_valid_s1;
            // Sender holds the identifier steady while the strobe crosses
            rx_id_s1       <= i_rx_id;
            rx_id_sync     <= rx_id_s1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_filter_n_on        <= '0;
            o_filter_mask_choice <= '0;
            o_filter_fifo_choice <= '0;
        end else begin
            for (int f = 0; f < FILTER_COUNT; f++) begin
                o_filter_n_on[f] <= next_ctrl[f*SLOT_WIDTH + ON_POS];
                o_filter_mask_choice[f*MASK_WIDTH +: MASK_WIDTH] <=
                    next_ctrl[f*SLOT_WIDTH + MASK_LSB +: MASK_WIDTH];
                o_filter_fifo_choice[f*FIFO_WIDTH +: FIFO_WIDTH] <=
                    next_ctrl[f*SLOT_WIDTH + FIFO_LSB +: FIFO_WIDTH];
            end
        end
    end

    always_comb begin
        for (int m = 0; m < MASK_COUNT; m++) begin
            mask_flat[m*ID_WIDTH +: ID_WIDTH] = mask_reg[m];
        end
    end

    // A filter matches only while the whole controller is switched on too
    for (genvar g = 0; g < FILTER_COUNT; g++) begin : g_match
        can_filter_match u_match (
            .i_clk_sys     (i_clk_sys),
            .i_rst_n       (i_rst_n),
            .i_on          (acceptance_filter_control_6[g*SLOT_WIDTH + ON_POS] && module_on),
            .i_mask_choice (acceptance_filter_control_6[g*SLOT_WIDTH + MASK_LSB +: MASK_WIDTH]),
            .i_filter_id   (i_filter_ids[g*ID_WIDTH +: ID_WIDTH]),
            .i_masks       (mask_flat),
            .i_rx_id       (rx_id_sync),
            .i_rx_valid    (rx_valid_sync),
            .o_hit         (o_filter_hit[g])
        );
    end
endmodule // can_acceptance_filter_control

// ===== can_filter_ctrl_pkg.sv
// Constants shared by the acceptance filter control slice
package can_filter_ctrl_pkg;
    localparam int          FILTER_COUNT      = 4;
    localparam int          FILTER_BASE_INDEX = 24;
    localparam int          SLOT_WIDTH        = 8;
    localparam int          ON_POS            = 7;
    localparam int          MASK_LSB          = 5;
    localparam int          MASK_WIDTH        = 2;
    localparam int          FIFO_LSB          = 0;
    localparam int          FIFO_WIDTH        = 5;
    localparam int          MASK_COUNT        = 4;
    localparam int          ID_WIDTH          = 29;
    localparam logic [3:0]  ADDR_FILTER_CTRL  = 4'h0;
    localparam logic [3:0]  ADDR_MODULE_CTRL  = 4'h4;
    localparam logic [3:0]  ADDR_MASK_BASE    = 4'h8;
    localparam logic [31:0] FILTER_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;
    localparam int          MODULE_ON_POS     = 15;
    localparam int          ACTIVE_FLAG_POS   = 11;
    localparam int          SHUTDOWN_NS       = 200;
    localparam int          CLK_PERIOD_NS     = 40;
    localparam int          SHUTDOWN_CYCLES   = (SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_type;
endpackage

// ===== can_filter_match.sv
// Per-filter identifier compare against the selected acceptance mask
`timescale 1ns/100ps
module can_filter_match
    import can_filter_ctrl_pkg::*;
(
    input  wire logic                             i_clk_sys,
    input  wire logic                             i_rst_n,
    input  wire logic                             i_on,
    input  wire logic [MASK_WIDTH-1:0]            i_mask_choice,
    input  wire logic [ID_WIDTH-1:0]              i_filter_id,
    input  wire logic [MASK_COUNT*ID_WIDTH-1:0]   i_masks,
    input  wire logic [ID_WIDTH-1:0]              i_rx_id,
    input  wire logic                             i_rx_valid,
    output logic                                  o_hit
);
    logic                next_hit;
    logic [ID_WIDTH-1:0] sel_mask;

    always_comb begin
        sel_mask = i_masks[i_mask_choice*ID_WIDTH +: ID_WIDTH];
        next_hit = i_rx_valid && i_on
                   && (((i_rx_id ^ i_filter_id) & sel_mask) == '0);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hit <= 1'b0;
        end else begin
            o_hit <= next_hit;
        end
    end
endmodule // can_filter_match

// ===== can_filter_ctrl_assertions.sv
// Checker for the acceptance filter control slice ports
`timescale 1ns/100ps
module can_filter_ctrl_assertions
    import can_filter_ctrl_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    input wire logic [3:0]  i_address,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic        i_rx_valid,
    input wire logic [31:0] o_readdata,
    input wire logic        o_waitrequest,
    input wire logic [3:0]  o_filter_n_on,
    input wire logic [7:0]  o_filter_mask_choice,
    input wire logic [19:0] o_filter_fifo_choice,
    input wire logic [3:0]  o_filter_hit,
    input wire logic        o_controller_active_flag
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic acc;
    assign acc = i_write && !o_waitrequest;
    sequence s_req; (i_read || i_write) && o_waitrequest; endsequence
    sequence s_ans; ##[1:2] !o_waitrequest; endsequence
    chk_bus_answer: assert property (s_req |-> s_ans) else $error("no bus answer");
    chk_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest) else $error("long ack");
    chk_read_stand: assert property ($changed(o_readdata) |-> !o_waitrequest)
        else $error("readdata moved");
    // Only reset may clear a filter's enable output, since an enabled slot is frozen
    chk_on_hold: assert property (($past(o_filter_n_on) & ~o_filter_n_on) == 4'h0)
        else $error("enable fell");
    chk_field_cause: assert property ($changed({o_filter_mask_choice, o_filter_fifo_choice})
        |-> $past(acc) || $past(acc, 2)) else $error("field moved without write");
    chk_hit_on: assert property ((o_filter_hit & ~o_filter_n_on) == 4'h0)
        else $error("hit on disabled filter");
    chk_hit_delay: assert property (|o_filter_hit |-> $past(i_rx_valid, 3))
        else $error("hit without valid");
    chk_flag_cause: assert property ($rose(o_controller_active_flag) |->
        $past(acc && i_address == ADDR_MODULE_CTRL) ||
        $past(acc && i_address == ADDR_MODULE_CTRL, 2)) else $error("flag rose alone");
    for (genvar k = 0; k < 4; k++) begin : g_slot
        chk_slot_frozen: assert property (o_filter_n_on[k] |=> $stable(o_filter_mask_choice[2*k+:2])
            && $stable(o_filter_fifo_choice[5*k+:5])) else $error("frozen slot changed");
    end
endmodule // can_filter_ctrl_assertions
bind can_acceptance_filter_control can_filter_ctrl_assertions u_chk (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_rx_valid(i_rx_valid), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_filter_n_on(o_filter_n_on),
    .o_filter_mask_choice(o_filter_mask_choice), .o_filter_fifo_choice(o_filter_fifo_choice),
    .o_filter_hit(o_filter_hit), .o_controller_active_flag(o_controller_active_flag));

// ===== can_acceptance_filter_control_tb_top.sv
// Self-checking bench for the acceptance filter control slice
`timescale 1ns/100ps
module can_acceptance_filter_control_tb_top;
    import can_filter_ctrl_pkg::*;
    logic        i_clk_sys = 1'b0, i_rst_n = 1'b0, i_read = 1'b0, i_write = 1'b0;
    logic [3:0]  i_address = 4'h0, i_byteenable = 4'hF;
    logic [31:0] i_writedata = 32'h0, o_readdata, q;
    logic [28:0] i_rx_id = 29'h0;
    logic        i_rx_valid = 1'b0, o_waitrequest, o_controller_active_flag;
    logic [115:0] i_filter_ids = {29'h1234567, 29'h1234560, 58'h0};
    logic [3:0]  o_filter_n_on, o_filter_hit, seen;
    logic [7:0]  o_filter_mask_choice;
    logic [19:0] o_filter_fifo_choice;
    int          n_mismatch = 0, compares = 0, cycles = 0;
    always #20 i_clk_sys = ~i_clk_sys;
    can_acceptance_filter_control #(.SHUTDOWN_COUNT(8)) u_dut (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .i_rx_id(i_rx_id), .i_rx_valid(i_rx_valid), .i_filter_ids(i_filter_ids),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_filter_n_on(o_filter_n_on),
        .o_filter_mask_choice(o_filter_mask_choice), .o_filter_fifo_choice(o_filter_fifo_choice),
        .o_filter_hit(o_filter_hit), .o_controller_active_flag(o_controller_active_flag));
    task end_sim();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Watchdog sized well above the whole sequence
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_write <= w;
        i_read <= !w;
        i_address <= a;
        i_writedata <= d;
        @(posedge i_clk_sys);
        while (o_waitrequest !== 1'b0) @(posedge i_clk_sys);
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask
    task outs(input logic [3:0] on, input logic [7:0] m, input logic [19:0] f);
        repeat (2) @(posedge i_clk_sys);
        chk(32'(o_filter_n_on), 32'(on));
        chk(32'(o_filter_mask_choice), 32'(m));
        chk(32'(o_filter_fifo_choice), 32'(f));
    endtask
    task t_reset();
        bus(1'b0, ADDR_FILTER_CTRL, 32'h0);
        chk(q, FILTER_CTRL_RESET);
        outs(4'h0, 8'h00, 20'h0);
    endtask
    task t_fields();
        logic [7:0] b;
        for (int m = 0; m < 4; m++) begin
            b = {1'b0, 2'(m), (m == 3) ? 5'd31 : 5'(m * 8)};
            bus(1'b1, ADDR_FILTER_CTRL, {4{b}});
            bus(1'b0, ADDR_FILTER_CTRL, 32'h0);
            chk(q, {4{b}});
            outs(4'h0, {4{b[6:5]}}, {4{b[4:0]}});
        end
        bus(1'b1, ADDR_FILTER_CTRL, 32'h0);
    endtask
    task t_unmapped();
        bus(1'b1, 4'(ADDR_MASK_BASE + 3), 32'hFFFF_FFFF);
        bus(1'b1, 4'hF, 32'hFFFF_FFFF);
        bus(1'b0, 4'hF, 32'h0);
        chk(q, UNMAPPED_READ);
        bus(1'b0, 4'(ADDR_MASK_BASE + 3), 32'h0);
        chk(q, 32'h1FFF_FFFF);
        bus(1'b0, ADDR_FILTER_CTRL, 32'h0);
        chk(q, 32'h0);
    endtask
    task rx(input logic [28:0] id, input logic [3:0] exp);
        seen = 4'h0;
        @(posedge i_clk_sys);
        i_rx_id <= id;
        i_rx_valid <= 1'b1;
        @(posedge i_clk_sys);
        i_rx_valid <= 1'b0;
        repeat (8) begin
            @(posedge i_clk_sys);
            seen = seen | o_filter_hit;
        end
        chk(32'(seen), 32'(exp));
    endtask
    task t_match();
        bus(1'b1, 4'(ADDR_MASK_BASE + 1), 32'h1FFF_FFFF);
        bus(1'b1, 4'(ADDR_MASK_BASE + 2), 32'h1FFF_FFF0);
        bus(1'b1, ADDR_MODULE_CTRL, 32'h0000_8000);
        rx(29'h1234567, 4'h0);
        // Slot 27 exact on mask 1, slot 26 ignores low nibble through mask 2
        bus(1'b1, ADDR_FILTER_CTRL, 32'hA3C4_0000);
        outs(4'hC, 8'h60, 20'h19000);
        rx(29'h1234567, 4'hC);
        rx(29'h0234567, 4'h0);
    endtask
    task t_lock();
        i_byteenable <= 4'h7;
        bus(1'b1, ADDR_FILTER_CTRL, 32'h0011_1F07);
        i_byteenable <= 4'hF;
        bus(1'b0, ADDR_FILTER_CTRL, 32'h0);
        chk(q, 32'hA3C4_1F07);
        bus(1'b1, ADDR_FILTER_CTRL, 32'h0);
        outs(4'hC, 8'h60, 20'h19000);
    endtask
    task t_active();
        int n;
        bus(1'b0, ADDR_MODULE_CTRL, 32'h0);
        chk(32'(q[MODULE_ON_POS]), 32'h1);
        chk(32'(q[ACTIVE_FLAG_POS]), 32'h1);
        bus(1'b1, ADDR_MODULE_CTRL, 32'h0);
        chk(32'(o_controller_active_flag), 32'h1);
        n = 0;
        while (o_controller_active_flag !== 1'b0 && n < 20) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk(32'(n >= 8 && n < 20), 32'h1);
        bus(1'b0, ADDR_MODULE_CTRL, 32'h0);
        chk(32'(q[ACTIVE_FLAG_POS]), 32'h0);
        chk(32'(q[MODULE_ON_POS]), 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        t_reset();
        t_fields();
        t_unmapped();
        t_match();
        t_lock();
        t_active();
        end_sim();
    end
endmodule // can_acceptance_filter_control_tb_top
